// ===== design/cpud_decoder.v
// instruction fetch, length and effective address decoder
//
// Function
// - inherent instructions are one byte
// - immediate takes opcode plus operand byte
// - short direct uses one address byte
// - long direct uses two address bytes
// - indexed address is index plus offset
// - no-offset indexed has no extension byte
// - short indexed sum spans 00 to 1FE
// - long indexed uses sixteen-bit offset
// - short indirect fetches one-byte pointer
// - long indirect fetches sixteen-bit pointer
// - indirect indexed adds index and pointer
// - short indirect indexed sums to 1FE
// - relative adds signed byte to PC
// - relative offset direct or from memory
// - short-only and long-capable operation groups
// - instructions one to four bytes long
// - fetch prefix, opcode, then extension bytes
// - prefix 90 selects second index register
// - prefix 92 turns direct into indirect
// - prefix 92 turns offset indexed into indirect indexed
// - prefix 91 moves indirect indexed to Y
// - decode sixty-three operations into classes
// - undefined byte raises illegal code reset
// - prefix plus valid opcode never resets
// - relative base is next instruction address
`timescale 1ns/1ps
`default_nettype none
`include "cpud_consts.vh"
module cpud_decoder (
	input  wire        clock,
	input  wire        rst,
	input  wire        start,
	input  wire [15:0] start_pc,
	input  wire [7:0]  index_x,
	input  wire [7:0]  index_y,
	output wire        mem_rd,
	output wire [15:0] mem_addr,
	input  wire [7:0]  mem_rdata,
	input  wire        mem_ready,
	output wire        busy,
	output reg         done,
	output reg         illegal_reset,
	output reg  [7:0]  opcode_out,
	output reg  [7:0]  prefix_out,
	output reg  [4:0]  mode_out,
	output reg  [3:0]  class_out,
	output reg         use_y_out,
	output reg  [2:0]  length_out,
	output reg  [15:0] ea_out,
	output reg  [7:0]  operand_out,
	output reg  [15:0] target_out,
	output reg  [15:0] next_pc_out
);
	// one-hot fetch sequence
	localparam [4:0] S_IDLE = 5'b00001;
	localparam [4:0] S_OP   = 5'b00010;
	localparam [4:0] S_EXT  = 5'b00100;
	localparam [4:0] S_PTR  = 5'b01000;
	localparam [4:0] S_DONE = 5'b10000;

	// decode state, gathered bytes and their counters
	reg  [4:0]  state_reg;
	reg  [15:0] pc_reg;
	reg  [15:0] start_reg;
	reg  [7:0]  prefix_reg;
	reg  [7:0]  opcode_reg;
	reg  [4:0]  mode_reg;
	reg  [3:0]  class_reg;
	reg         use_y_reg;
	reg  [7:0]  ext1_reg;
	reg  [7:0]  ext2_reg;
	reg  [1:0]  ext_left_reg;
	reg         ext_second_reg;
	reg  [1:0]  ptr_cnt_reg;
	reg  [1:0]  ptr_left_reg;
	reg  [15:0] ptr_addr_reg;
	reg  [7:0]  ptr_hi_reg;
	reg  [7:0]  ptr_lo_reg;

	// classifier results for the byte now on the bus
	wire [4:0]  cls_mode;
	wire [1:0]  cls_ext;
	wire [1:0]  cls_ptr;
	wire        cls_use_y;
	wire        cls_illegal;
	wire [3:0]  cls_class;

	// the byte on the bus is classified against the prefix already seen
	cpud_classify u_classify (
		.opcode   (mem_rdata),
		.prefix   (prefix_reg),
		.mode     (cls_mode),
		.ext_cnt  (cls_ext),
		.ptr_cnt  (cls_ptr),
		.use_y    (cls_use_y),
		.illegal  (cls_illegal),
		.op_class (cls_class)
	);

	// a prefix is only one when no prefix has been taken yet
	function is_prefix;
		input [7:0] b;
		is_prefix = (b == `CPUD_PRE_Y) || (b == `CPUD_PRE_IND_Y) ||
			(b == `CPUD_PRE_IND);
	endfunction

	// sign extension of a relative byte to the PC width
	function [15:0] sext8;
		input [7:0] b;
		sext8 = {{8{b[7]}}, b};
	endfunction

	// handshake toward memory: a read stands until mem_ready
	assign mem_rd   = (state_reg == S_OP) ||
		(state_reg == S_EXT) ||
		(state_reg == S_PTR);
	assign mem_addr = (state_reg == S_PTR) ? ptr_addr_reg : pc_reg;
	assign busy     = (state_reg != S_IDLE);

	// index values are read late, so they must hold while busy
	wire        take      = mem_rd && mem_ready;
	wire [15:0] pc_inc    = pc_reg + 16'h0001;
	wire [15:0] ptr_inc   = ptr_addr_reg + 16'h0001;
	wire [7:0]  index_sel = use_y_reg ? index_y : index_x;
	wire [15:0] index16   = {8'h00, index_sel};
	wire [15:0] word_ext  = {ext1_reg, ext2_reg};
	wire [15:0] word_ptr  = {ptr_hi_reg, ptr_lo_reg};
	// length counts every byte fetched at the PC, prefix included
	wire [15:0] len_full  = pc_reg - start_reg;

	// effective address and relative target from the gathered bytes
	// long sums wrap at 64K, as the address space does
	reg  [15:0] ea_calc;
	reg  [7:0]  rel_byte;
	always @* begin
		ea_calc  = `CPUD_RST_WORD;
		rel_byte = ext1_reg;
		case (mode_reg)
			`CPUD_M_DIR_S, `CPUD_M_BIT_D: ea_calc = {8'h00, ext1_reg};
			`CPUD_M_BREL_D: begin
				ea_calc  = {8'h00, ext1_reg};
				rel_byte = ext2_reg;
			end
			`CPUD_M_DIR_L:  ea_calc = word_ext;
			`CPUD_M_IDX0:   ea_calc = index16;
			`CPUD_M_IDX_S:  ea_calc = index16 + {8'h00, ext1_reg};
			`CPUD_M_IDX_L:  ea_calc = index16 + word_ext;
			`CPUD_M_IND_S, `CPUD_M_BIT_I: ea_calc = {8'h00, ptr_lo_reg};
			`CPUD_M_BREL_I: begin
				ea_calc  = {8'h00, ptr_lo_reg};
				rel_byte = ext2_reg;
			end
			`CPUD_M_IND_L:  ea_calc = word_ptr;
			`CPUD_M_IIDX_S: ea_calc = index16 + {8'h00, ptr_lo_reg};
			`CPUD_M_IIDX_L: ea_calc = index16 + word_ptr;
			`CPUD_M_REL_I:  rel_byte = ptr_lo_reg;
			default:        ea_calc = `CPUD_RST_WORD;
		endcase
	end

	// pc_reg already points past the last byte here, so no adjust
	// a negative offset may land below the start address
	wire [15:0] target_calc = pc_reg + sext8(rel_byte);

	// main fetch sequencer
	always @(posedge clock) begin
		if (rst) begin
			// outputs clear as well, so length reads zero until a decode ends
			state_reg      <= S_IDLE;
			pc_reg         <= `CPUD_RST_WORD;
			start_reg      <= `CPUD_RST_WORD;
			prefix_reg     <= `CPUD_PRE_NONE;
			opcode_reg     <= `CPUD_RST_BYTE;
			mode_reg       <= `CPUD_M_INH;
			class_reg      <= `CPUD_C_LOAD;
			use_y_reg      <= 1'b0;
			ext1_reg       <= `CPUD_RST_BYTE;
			ext2_reg       <= `CPUD_RST_BYTE;
			ext_left_reg   <= 2'd0;
			ext_second_reg <= 1'b0;
			ptr_cnt_reg    <= 2'd0;
			ptr_left_reg   <= 2'd0;
			ptr_addr_reg   <= `CPUD_RST_WORD;
			ptr_hi_reg     <= `CPUD_RST_BYTE;
			ptr_lo_reg     <= `CPUD_RST_BYTE;
			done           <= 1'b0;
			illegal_reset  <= 1'b0;
			opcode_out     <= `CPUD_RST_BYTE;
			prefix_out     <= `CPUD_PRE_NONE;
			mode_out       <= `CPUD_M_INH;
			class_out      <= `CPUD_C_LOAD;
			use_y_out      <= 1'b0;
			length_out     <= 3'd0;
			ea_out         <= `CPUD_RST_WORD;
			operand_out    <= `CPUD_RST_BYTE;
			target_out     <= `CPUD_RST_WORD;
			next_pc_out    <= `CPUD_RST_WORD;
		end else begin
			done          <= 1'b0;
			illegal_reset <= 1'b0;
			case (state_reg)
				// wait for a launch; start is ignored in every other state
				S_IDLE: begin
					if (start) begin
						pc_reg     <= start_pc;
						start_reg  <= start_pc;
						// a fresh launch forgets the prefix of the last decode
						prefix_reg <= `CPUD_PRE_NONE;
						state_reg  <= S_OP;
					end
				end

				// prefix or opcode byte, one per taken read
				S_OP: begin
					if (take) begin
						pc_reg <= pc_inc;
						if (is_prefix(mem_rdata) && (prefix_reg == `CPUD_PRE_NONE)) begin
							prefix_reg <= mem_rdata;
						end else if (cls_illegal) begin
							// second prefix or undefined opcode
							illegal_reset <= 1'b1;
							state_reg     <= S_IDLE;
						end else begin
							// unauthorised prefix pairs fall back to the base mode
							opcode_reg     <= mem_rdata;
							mode_reg       <= cls_mode;
							class_reg      <= cls_class;
							use_y_reg      <= cls_use_y;
							ext_left_reg   <= cls_ext;
							ext_second_reg <= 1'b0;
							ptr_cnt_reg    <= cls_ptr;
							ext1_reg       <= `CPUD_RST_BYTE;
							ext2_reg       <= `CPUD_RST_BYTE;
							ptr_hi_reg     <= `CPUD_RST_BYTE;
							ptr_lo_reg     <= `CPUD_RST_BYTE;
							state_reg      <= (cls_ext == 2'd0) ? S_DONE : S_EXT;
						end
					end
				end

				// extension bytes follow the opcode in address order
				S_EXT: begin
					if (take) begin
						pc_reg <= pc_inc;
						if (ext_second_reg) begin
							ext2_reg <= mem_rdata;
						end else begin
							ext1_reg <= mem_rdata;
						end
						ext_second_reg <= 1'b1;
						ext_left_reg   <= ext_left_reg - 2'd1;
						if (ext_left_reg == 2'd1) begin
							// the pointer address is always the first extension byte
							ptr_addr_reg <= {8'h00, ext_second_reg ? ext1_reg : mem_rdata};
							ptr_left_reg <= ptr_cnt_reg;
							state_reg    <= (ptr_cnt_reg == 2'd0) ? S_DONE : S_PTR;
						end
					end
				end

				// pointer bytes come from page zero; a long pointer at FF takes its low byte from 0100
				S_PTR: begin
					if (take) begin
						ptr_addr_reg <= ptr_inc;
						ptr_left_reg <= ptr_left_reg - 2'd1;
						// of a two-byte pointer the first byte read is the high one
						if (ptr_left_reg == 2'd2) begin
							ptr_hi_reg <= mem_rdata;
						end else begin
							ptr_lo_reg <= mem_rdata;
							state_reg  <= S_DONE;
						end
					end
				end

				// publish the results together with one done pulse
				S_DONE: begin
					// operand access waits for this point, after the pointer is in
					done        <= 1'b1;
					opcode_out  <= opcode_reg;
					prefix_out  <= prefix_reg;
					mode_out    <= mode_reg;
					class_out   <= class_reg;
					use_y_out   <= use_y_reg;
					length_out  <= len_full[2:0];
					ea_out      <= ea_calc;
					operand_out <= ext1_reg;
					target_out  <= target_calc;
					next_pc_out <= pc_reg;
					state_reg   <= S_IDLE;
				end

				// a corrupt state code falls back to idle
				default: state_reg <= S_IDLE;
			endcase
		end
	end
endmodule // cpud_decoder
`default_nettype wire

// ===== design/cpud_consts.vh
// constants for the addressing mode decoder
`ifndef CPUD_CONSTS_VH
`define CPUD_CONSTS_VH
// prefix bytes
`define CPUD_PRE_Y      8'h90
`define CPUD_PRE_IND_Y  8'h91
`define CPUD_PRE_IND    8'h92
`define CPUD_PRE_NONE   8'h00
// addressing modes
`define CPUD_M_INH      5'h00
`define CPUD_M_IMM      5'h01
`define CPUD_M_DIR_S    5'h02
`define CPUD_M_DIR_L    5'h03
`define CPUD_M_IDX0     5'h04
`define CPUD_M_IDX_S    5'h05
`define CPUD_M_IDX_L    5'h06
`define CPUD_M_IND_S    5'h07
`define CPUD_M_IND_L    5'h08
`define CPUD_M_IIDX_S   5'h09
`define CPUD_M_IIDX_L   5'h0A
`define CPUD_M_REL_D    5'h0B
`define CPUD_M_REL_I    5'h0C
`define CPUD_M_BIT_D    5'h0D
`define CPUD_M_BIT_I    5'h0E
`define CPUD_M_BREL_D   5'h0F
`define CPUD_M_BREL_I   5'h10
// operation classes
`define CPUD_C_LOAD     4'h0
`define CPUD_C_STACK    4'h1
`define CPUD_C_ARITH    4'h2
`define CPUD_C_LOGIC    4'h3
`define CPUD_C_BIT      4'h4
`define CPUD_C_SHIFT    4'h5
`define CPUD_C_JUMP     4'h6
`define CPUD_C_INT      4'h7
`define CPUD_C_FLAG     4'h8
// opcode high nibble groups
`define CPUD_G_BTJ      4'h0
`define CPUD_G_BSR      4'h1
`define CPUD_G_JR       4'h2
`define CPUD_G_RMW_D    4'h3
`define CPUD_G_RMW_A    4'h4
`define CPUD_G_RMW_X    4'h5
`define CPUD_G_RMW_IS   4'h6
`define CPUD_G_RMW_I0   4'h7
`define CPUD_G_MISC     4'h8
`define CPUD_G_XFER     4'h9
`define CPUD_G_IMM      4'hA
`define CPUD_G_DIR_S    4'hB
`define CPUD_G_DIR_L    4'hC
`define CPUD_G_IDX_L    4'hD
`define CPUD_G_IDX_S    4'hE
`define CPUD_G_IDX0     4'hF
// reset values
`define CPUD_RST_BYTE   8'h00
`define CPUD_RST_WORD   16'h0000
`endif

// ===== design/cpud_classify.v
// opcode and prefix classification into mode, byte counts and class
`timescale 1ns/1ps
`default_nettype none
`include "cpud_consts.vh"
module cpud_classify (
	input  wire [7:0] opcode,
	input  wire [7:0] prefix,
	output reg  [4:0] mode,
	output reg  [1:0] ext_cnt,
	output reg  [1:0] ptr_cnt,
	output wire       use_y,
	output reg        illegal,
	output reg  [3:0] op_class
);
	wire [3:0] hi = opcode[7:4];
	wire [3:0] lo = opcode[3:0];
	reg  [4:0] base;

	// holes in the read-modify-write rows
	function rmw_hole;
		input [3:0] l;
		rmw_hole = (l == 4'h1) || (l == 4'h2) || (l == 4'h5) || (l == 4'hB);
	endfunction

	// base mode from the high nibble, then prefix conversion
	always @* begin
		case (hi)
			`CPUD_G_BTJ:    base = `CPUD_M_BREL_D;
			`CPUD_G_BSR:    base = `CPUD_M_BIT_D;
			`CPUD_G_JR:     base = `CPUD_M_REL_D;
			`CPUD_G_RMW_D:  base = `CPUD_M_DIR_S;
			`CPUD_G_RMW_IS: base = `CPUD_M_IDX_S;
			`CPUD_G_RMW_I0: base = `CPUD_M_IDX0;
			`CPUD_G_IMM:    base = `CPUD_M_IMM;
			`CPUD_G_DIR_S:  base = `CPUD_M_DIR_S;
			`CPUD_G_DIR_L:  base = `CPUD_M_DIR_L;
			`CPUD_G_IDX_L:  base = `CPUD_M_IDX_L;
			`CPUD_G_IDX_S:  base = `CPUD_M_IDX_S;
			`CPUD_G_IDX0:   base = `CPUD_M_IDX0;
			default:        base = `CPUD_M_INH;
		endcase
		mode = base;
		if (prefix == `CPUD_PRE_IND) begin
			case (base)
				`CPUD_M_DIR_S:  mode = `CPUD_M_IND_S;
				`CPUD_M_DIR_L:  mode = `CPUD_M_IND_L;
				`CPUD_M_BIT_D:  mode = `CPUD_M_BIT_I;
				`CPUD_M_BREL_D: mode = `CPUD_M_BREL_I;
				`CPUD_M_REL_D:  mode = `CPUD_M_REL_I;
				`CPUD_M_IDX_S:  mode = `CPUD_M_IIDX_S;
				`CPUD_M_IDX_L:  mode = `CPUD_M_IIDX_L;
				default:        mode = base;
			endcase
		end else if (prefix == `CPUD_PRE_IND_Y) begin
			case (base)
				`CPUD_M_IDX_S: mode = `CPUD_M_IIDX_S;
				`CPUD_M_IDX_L: mode = `CPUD_M_IIDX_L;
				default:       mode = base;
			endcase
		end
	end

	// Y selection: 90 for plain forms, 91 for indirect indexed
	assign use_y = (prefix == `CPUD_PRE_Y) || (prefix == `CPUD_PRE_IND_Y);

	// extension and pointer byte counts per mode
	always @* begin
		ptr_cnt = 2'd0;
		case (mode)
			`CPUD_M_INH, `CPUD_M_IDX0: ext_cnt = 2'd0;
			`CPUD_M_DIR_L, `CPUD_M_IDX_L: ext_cnt = 2'd2;
			`CPUD_M_BREL_D: ext_cnt = 2'd2;
			`CPUD_M_BREL_I: begin
				ext_cnt = 2'd2;
				ptr_cnt = 2'd1;
			end
			`CPUD_M_IND_L, `CPUD_M_IIDX_L: begin
				ext_cnt = 2'd1;
				ptr_cnt = 2'd2;
			end
			`CPUD_M_IND_S, `CPUD_M_IIDX_S, `CPUD_M_REL_I, `CPUD_M_BIT_I: begin
				ext_cnt = 2'd1;
				ptr_cnt = 2'd1;
			end
			default: ext_cnt = 2'd1;
		endcase
	end

	// operation class and undefined codes
	always @* begin
		illegal = 1'b0;
		op_class = `CPUD_C_LOAD;
		case (hi)
			`CPUD_G_BTJ, `CPUD_G_BSR: op_class = `CPUD_C_BIT;
			`CPUD_G_JR: op_class = `CPUD_C_JUMP;
			`CPUD_G_RMW_D, `CPUD_G_RMW_A, `CPUD_G_RMW_X, `CPUD_G_RMW_IS, `CPUD_G_RMW_I0: begin
				illegal = rmw_hole(lo);
				case (lo)
					4'h0, 4'h3: op_class = `CPUD_C_LOGIC;
					4'hA, 4'hC, 4'hD: op_class = `CPUD_C_ARITH;
					4'hF: op_class = `CPUD_C_LOAD;
					default: op_class = `CPUD_C_SHIFT;
				endcase
			end
			`CPUD_G_MISC: begin
				illegal = (lo == 4'hC) || (lo == 4'hD);
				case (lo)
					4'h0, 4'h3, 4'hE, 4'hF: op_class = `CPUD_C_INT;
					4'h1: op_class = `CPUD_C_JUMP;
					4'h2: op_class = `CPUD_C_ARITH;
					default: op_class = `CPUD_C_STACK;
				endcase
			end
			`CPUD_G_XFER: begin
				illegal = (lo < 4'h3);
				case (lo)
					4'h8, 4'h9, 4'hA, 4'hB: op_class = `CPUD_C_FLAG;
					4'hC: op_class = `CPUD_C_STACK;
					4'hD: op_class = `CPUD_C_JUMP;
					default: op_class = `CPUD_C_LOAD;
				endcase
			end
			default: begin
				// rows A..F: jumps and calls have no long direct or long indexed form
				illegal = ((hi == `CPUD_G_IMM) &&
					((lo == 4'h7) || (lo == 4'hC) || (lo == 4'hF))) ||
					(((hi == `CPUD_G_DIR_L) || (hi == `CPUD_G_IDX_L)) &&
					((lo == 4'hC) || (lo == 4'hD)));
				case (lo)
					4'h0, 4'h2, 4'h9, 4'hB: op_class = `CPUD_C_ARITH;
					4'h4, 4'h5, 4'h8, 4'hA: op_class = `CPUD_C_LOGIC;
					4'hC, 4'hD: op_class = `CPUD_C_JUMP;
					default: op_class = `CPUD_C_LOAD;
				endcase
			end
		endcase
	end
endmodule // cpud_classify
`default_nettype wire

// ===== verif/cpud_mem_model.sv
// behavioural program and data memory on the far side of the decoder
`timescale 1ns/1ps
`default_nettype none
module cpud_mem_model (
	input  wire logic        clock,
	input  wire logic        slow,
	input  wire logic        mem_rd,
	input  wire logic [15:0] mem_addr,
	output logic      [7:0]  mem_rdata,
	output logic             mem_ready
);
	logic [7:0] mem [0:65535];
	logic [7:0] last_reg;
	logic [1:0] wait_reg;
	// known start so slow mode never answers unknown
	initial begin
		wait_reg = 2'h0;
		last_reg = 8'h00;
	end
	// slow mode answers on the third cycle of a held request
	always @(posedge clock) begin
		if (mem_rd && !mem_ready) wait_reg <= wait_reg + 2'h1;
		else wait_reg <= 2'h0;
		if (mem_ready) last_reg <= mem[mem_addr];
	end
	assign mem_ready = mem_rd && (!slow || wait_reg == 2'h2);
	// off the answer the bus shows the inverse, never a stale byte
	assign mem_rdata = mem_ready ? mem[mem_addr] : ~last_reg;
endmodule // cpud_mem_model
`default_nettype wire

// ===== verif/cpud_dec_chk_assertions.sv
// concurrent checks on the addressing mode decoder ports
`timescale 1ns/1ps
`default_nettype none
`include "cpud_consts.vh"
module cpud_dec_chk (
	input wire logic        clock,
	input wire logic        rst,
	input wire logic        start,
	input wire logic [15:0] start_pc,
	input wire logic [7:0]  index_x,
	input wire logic [7:0]  index_y,
	input wire logic        mem_rd,
	input wire logic [15:0] mem_addr,
	input wire logic        mem_ready,
	input wire logic        busy,
	input wire logic        done,
	input wire logic        illegal_reset,
	input wire logic [7:0]  prefix_out,
	input wire logic [4:0]  mode_out,
	input wire logic        use_y_out,
	input wire logic [2:0]  length_out,
	input wire logic [15:0] ea_out,
	input wire logic [7:0]  operand_out,
	input wire logic [15:0] target_out,
	input wire logic [15:0] next_pc_out
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	logic [15:0] pc_reg;
	wire  [7:0]  idx = use_y_out ? index_y : index_x;
	// start address kept so the next address can be checked against it
	always @(posedge clock) begin
		if (rst) pc_reg <= 16'h0000;
		else if (start && !busy) pc_reg <= start_pc;
	end
	// a decode is launched and must end in bounded time
	sequence s_launch; start && !busy; endsequence
	sequence s_finish; ##[1:80] (done || illegal_reset); endsequence
	property p_finish; s_launch |-> s_finish; endproperty
	a_finish: assert property (p_finish) else $error("decode never ended");
	property p_launch; s_launch |=> busy; endproperty
	a_launch: assert property (p_launch) else $error("start not taken");
	property p_hold; mem_rd && !mem_ready |=> mem_rd && $stable(mem_addr); endproperty
	a_hold: assert property (p_hold) else $error("read dropped or moved");
	property p_pulse; done |=> !done; endproperty
	a_pulse: assert property (p_pulse) else $error("done longer than a cycle");
	property p_excl; illegal_reset |-> !done; endproperty
	a_excl: assert property (p_excl) else $error("done with illegal reset");
	property p_len; done |-> length_out >= 3'h1 && length_out <= 3'h4; endproperty
	a_len: assert property (p_len) else $error("length out of range");
	property p_next; done |-> next_pc_out == pc_reg + {13'h0000, length_out}; endproperty
	a_next: assert property (p_next) else $error("next address wrong");
	property p_inh;
		done && mode_out == `CPUD_M_INH |-> length_out == ((prefix_out == 8'h00) ? 3'h1 : 3'h2);
	endproperty
	a_inh: assert property (p_inh) else $error("inherent length wrong");
	property p_imm;
		done && mode_out == `CPUD_M_IMM |-> length_out == ((prefix_out == 8'h00) ? 3'h2 : 3'h3);
	endproperty
	a_imm: assert property (p_imm) else $error("immediate length wrong");
	property p_idxs;
		done && mode_out == `CPUD_M_IDX_S |-> ea_out == {8'h00, operand_out} + {8'h00, idx};
	endproperty
	a_idxs: assert property (p_idxs) else $error("short indexed sum wrong");
	property p_rel;
		done && mode_out == `CPUD_M_REL_D
			|-> target_out == next_pc_out + {{8{operand_out[7]}}, operand_out};
	endproperty
	a_rel: assert property (p_rel) else $error("relative target wrong");
endmodule // cpud_dec_chk
bind cpud_decoder cpud_dec_chk i_chk (.clock, .rst, .start, .start_pc, .index_x, .index_y,
	.mem_rd, .mem_addr, .mem_ready, .busy, .done, .illegal_reset, .prefix_out, .mode_out,
	.use_y_out, .length_out, .ea_out, .operand_out, .target_out, .next_pc_out);
`default_nettype wire

// ===== verif/cpu_addressing_mode_decoder_bench.sv
// self-checking bench for the addressing mode decoder
`timescale 1ns/1ps
`default_nettype none
`include "cpud_consts.vh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin failures++; \
	$display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module cpu_addressing_mode_decoder_bench;
	typedef struct packed {
		logic [31:0] code;
		logic [4:0]  mode;
		logic [2:0]  len;
		logic        y;
		logic [1:0]  sel;
		logic [15:0] exp;
		logic [3:0]  cls;
	} cpud_row_t;
	logic        clock = 1'b0, rst = 1'b1, start = 1'b0, slow = 1'b0;
	logic [15:0] start_pc = 16'h1000;
	logic [7:0]  index_x = 8'hF0, index_y = 8'h81;
	wire         mem_rd, mem_ready, busy, done, illegal_reset, use_y_out;
	wire  [15:0] mem_addr, ea_out, target_out, next_pc_out;
	wire  [7:0]  mem_rdata, opcode_out, prefix_out, operand_out;
	wire  [4:0]  mode_out;
	wire  [3:0]  class_out;
	wire  [2:0]  length_out;
	integer      failures = 0, checks_done = 0, r;
	cpud_row_t   row;
	// sel: 1 checks ea, 2 checks target, 3 checks operand
	cpud_row_t rows [0:22] = '{
		{32'h40000000, `CPUD_M_INH, 3'h1, 1'b0, 2'h0, 16'h0000, `CPUD_C_LOGIC},
		{32'hA65A0000, `CPUD_M_IMM, 3'h2, 1'b0, 2'h3, 16'h005A, `CPUD_C_LOAD},
		{32'hB6100000, `CPUD_M_DIR_S, 3'h2, 1'b0, 2'h1, 16'h0010, `CPUD_C_LOAD},
		{32'hC6123400, `CPUD_M_DIR_L, 3'h3, 1'b0, 2'h1, 16'h1234, `CPUD_C_LOAD},
		{32'hF6000000, `CPUD_M_IDX0, 3'h1, 1'b0, 2'h1, 16'h00F0, `CPUD_C_LOAD},
		{32'hE6FF0000, `CPUD_M_IDX_S, 3'h2, 1'b0, 2'h1, 16'h01EF, `CPUD_C_LOAD},
		{32'hD6123400, `CPUD_M_IDX_L, 3'h3, 1'b0, 2'h1, 16'h1324, `CPUD_C_LOAD},
		{32'h92B61000, `CPUD_M_IND_S, 3'h3, 1'b0, 2'h1, 16'h0034, `CPUD_C_LOAD},
		{32'h92C61000, `CPUD_M_IND_L, 3'h3, 1'b0, 2'h1, 16'h3456, `CPUD_C_LOAD},
		{32'h92E61000, `CPUD_M_IIDX_S, 3'h3, 1'b0, 2'h1, 16'h0124, `CPUD_C_LOAD},
		{32'h92D61000, `CPUD_M_IIDX_L, 3'h3, 1'b0, 2'h1, 16'h3546, `CPUD_C_LOAD},
		{32'h91E61000, `CPUD_M_IIDX_S, 3'h3, 1'b1, 2'h1, 16'h00B5, `CPUD_C_LOAD},
		{32'h90F60000, `CPUD_M_IDX0, 3'h2, 1'b1, 2'h1, 16'h0081, `CPUD_C_LOAD},
		{32'h90E6FF00, `CPUD_M_IDX_S, 3'h3, 1'b1, 2'h1, 16'h0180, `CPUD_C_LOAD},
		{32'h90A65A00, `CPUD_M_IMM, 3'h3, 1'b1, 2'h3, 16'h005A, `CPUD_C_LOAD},
		{32'h27800000, `CPUD_M_REL_D, 3'h2, 1'b0, 2'h2, 16'h0F82, `CPUD_C_JUMP},
		{32'h277F0000, `CPUD_M_REL_D, 3'h2, 1'b0, 2'h2, 16'h1081, `CPUD_C_JUMP},
		{32'h92271000, `CPUD_M_REL_I, 3'h3, 1'b0, 2'h2, 16'h1037, `CPUD_C_JUMP},
		{32'h92400000, `CPUD_M_INH, 3'h2, 1'b0, 2'h0, 16'h0000, `CPUD_C_LOGIC},
		{32'h01100500, `CPUD_M_BREL_D, 3'h3, 1'b0, 2'h2, 16'h1008, `CPUD_C_BIT},
		{32'h92011005, `CPUD_M_BREL_I, 3'h4, 1'b0, 2'h2, 16'h1009, `CPUD_C_BIT},
		{32'h11100000, `CPUD_M_BIT_D, 3'h2, 1'b0, 2'h1, 16'h0010, `CPUD_C_BIT},
		{32'h92111000, `CPUD_M_BIT_I, 3'h3, 1'b0, 2'h1, 16'h0034, `CPUD_C_BIT}};
	cpud_decoder i_dut (.clock, .rst, .start, .start_pc, .index_x, .index_y, .mem_rd,
		.mem_addr, .mem_rdata, .mem_ready, .busy, .done, .illegal_reset, .opcode_out,
		.prefix_out, .mode_out, .class_out, .use_y_out, .length_out, .ea_out, .operand_out,
		.target_out, .next_pc_out);
	cpud_mem_model i_mem (.clock, .slow, .mem_rd, .mem_addr, .mem_rdata, .mem_ready);
	// 100 MHz core clock
	always #5 clock = ~clock;
	// print counts and verdict, then stop
	task end_of_test;
		$display("checks %0d errors %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// load code at 1000, launch one decode, wait for its end
	task run(input logic [31:0] c, input logic s);
		integer i;
		for (i = 0; i < 4; i++) i_mem.mem[16'h1000 + i] = c[31 - 8 * i -: 8];
		@(posedge clock);
		start <= 1'b1;
		slow <= s;
		@(posedge clock);
		start <= 1'b0;
		i = 0;
		do begin
			@(negedge clock);
			i++;
		end while (done !== 1'b1 && illegal_reset !== 1'b1 && i < 80);
	endtask
	// main sequence: table twice (prompt then slow memory), then hand cases
	initial begin
		i_mem.mem[16'h0010] = 8'h34;
		i_mem.mem[16'h0011] = 8'h56;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		@(negedge clock);
		`CHK(busy, 1'b0)
		`CHK(mem_rd, 1'b0)
		`CHK(ea_out, 16'h0000)
		for (r = 0; r < 46; r++) begin
			row = rows[r % 23];
			run(row.code, r >= 23);
			`CHK(done, 1'b1)
			`CHK(mode_out, row.mode)
			`CHK(length_out, row.len)
			`CHK(use_y_out, row.y)
			`CHK(class_out, row.cls)
			`CHK(prefix_out, (row.code[31:28] == 4'h9) ? row.code[31:24] : 8'h00)
			`CHK(opcode_out, (row.code[31:28] == 4'h9) ? row.code[23:16] : row.code[31:24])
			`CHK(next_pc_out, 16'h1000 + {13'h0000, row.len})
			if (row.sel == 2'h1) `CHK(ea_out, row.exp)
			if (row.sel == 2'h2) `CHK(target_out, row.exp)
			if (row.sel == 2'h3) `CHK(operand_out, row.exp[7:0])
		end
		// undefined opcode; a prefix twice in a row comes after the jump case
		run(32'h31000000, 1'b0);
		`CHK(illegal_reset, 1'b1)
		`CHK(done, 1'b0)
		// a jump in long direct form is refused
		run(32'hCC123400, 1'b0);
		`CHK(illegal_reset, 1'b1)
		run(32'h92920000, 1'b1);
		`CHK(illegal_reset, 1'b1)
		// reset in the middle of a slow long indirect fetch
		for (r = 0; r < 4; r++) i_mem.mem[16'h1000 + r] = rows[8].code[31 - 8 * r -: 8];
		@(posedge clock);
		start <= 1'b1;
		@(posedge clock);
		start <= 1'b0;
		repeat (4) @(posedge clock);
		rst <= 1'b1;
		@(posedge clock);
		rst <= 1'b0;
		@(negedge clock);
		`CHK(busy, 1'b0)
		`CHK(mem_rd, 1'b0)
		`CHK(length_out, 3'h0)
		run(rows[10].code, 1'b0);
		`CHK(ea_out, rows[10].exp)
		end_of_test;
	end
	// watchdog: whole run needs under 500 cycles
	initial begin
		#100000;
		failures++;
		end_of_test;
	end
endmodule // cpu_addressing_mode_decoder_bench
`default_nettype wire
